// file: clk_ctrl_consts.svh
// Purpose: Shared constants of the dithered clock controller and its host.
// Assumes: Both ends run on hclk at 25 MHz.
// Notes:   Offsets, reset values and timing counts live here.
`ifndef CLK_CTRL_CONSTS_SVH
`define CLK_CTRL_CONSTS_SVH

// ********************************
// Device register pointers
// ********************************
`define PTR_DIV      8'h02
`define PTR_TRIM_HI  8'h08
`define PTR_TRIM_LO  8'h09
`define PTR_ADDR     8'h0D
`define PTR_BAND     8'h0E
`define PTR_FBAND    8'h37
`define PTR_COMMIT   8'h3F

// ********************************
// Device reset values, fills, limits and timing counts
// ********************************
`define RST_DIV      5'h00
`define RST_TRIM_HI  8'h7D
`define RST_TRIM_LO  2'b00
`define RST_ADDR     4'h0
`define FILL_DIV     3'b111
`define FILL_BAND    3'b111
`define FILL_ADDR    4'hF
`define EXP_MAX      4'd8
`define STAB_CYC     10'd512
`define NV_WRITE_CYC 1000

// ********************************
// Host register offsets, reset values and timing
// ********************************
`define HA_CTRL      8'h00
`define HA_CMD       8'h04
`define HA_DATA      8'h08
`define HA_STAT      8'h0C
`define HA_SLAVE     8'h10
`define RST_CTRL     3'b011
`define RST_SLAVE    7'h50
`define CLK_NS       40
`define PD_HOLD_NS   10000
`define OUT_MAX_CYC  512
`define PD_HOLD_CYC  ((`PD_HOLD_NS + `CLK_NS - 1) / `CLK_NS + 2 * `OUT_MAX_CYC)
`define LINK_QTR_CYC 4

`endif

// file: clk_ctrl_pkg.sv
// Purpose: Types shared by both ends of the clock controller link.
// Assumes: Nothing beyond SystemVerilog packages.
// Notes:   Constants are in clk_ctrl_consts.svh.
package clk_ctrl_pkg;

   typedef enum logic [2:0] {
      SL_IDLE  = 3'b000,
      SL_ADDR  = 3'b001,
      SL_PTR   = 3'b010,
      SL_WDATA = 3'b011,
      SL_RDATA = 3'b100
   } sl_state_t;

   typedef enum logic [2:0] {
      M_IDLE  = 3'b000,
      M_START = 3'b001,
      M_WBYTE = 3'b010,
      M_RBYTE = 3'b011,
      M_STOP  = 3'b100
   } m_state_t;

endpackage

// file: clk_ctrl_link_if.sv
// Purpose: Two-wire link and control pins between host and device.
// Assumes: Open-drain lines are pulled high when nobody drives.
// Notes:   Line levels are resolved here from the enables.
`timescale 1ns/1ps
`default_nettype none
interface clk_ctrl_link_if;
   logic scl_oe;
   logic sda_host_oe;
   logic sda_dev_oe;
   logic scl;
   logic sda;
   logic out_gate;
   logic power_down_n;
   logic dither_enable_pin;
   logic clk_out;

   assign scl = ~scl_oe;
   assign sda = ~(sda_host_oe | sda_dev_oe);

   modport dev (
      input  scl, sda, out_gate, power_down_n, dither_enable_pin,
      output sda_dev_oe, clk_out
   );
   modport host (
      input  sda, clk_out,
      output scl_oe, sda_host_oe, out_gate, power_down_n, dither_enable_pin
   );
endinterface
`default_nettype wire

// file: dither_clk_dev.sv
// Purpose: Device end: register bank on the two-wire link, output
//          divider, gating, start-up delay and storage commit.
// Assumes: The master oscillator is modelled as hclk / 2.
// Notes:   Analog core takes trim, band and dither controls.
//
// The register addresses and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "clk_ctrl_consts.svh"
module dither_clk_dev
   import clk_ctrl_pkg::*;
#(
   parameter logic [3:0] DEV_ID       = 4'hA,   // Arbitrary value.
   parameter logic [4:0] FACTORY_BAND = 5'h12,
   parameter int         NV_WRITE_CYC = `NV_WRITE_CYC
) (
   // System
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // Link
   clk_ctrl_link_if.dev    lnk,
   // Oscillator core controls
   output var  logic       osc_run,
   output var  logic [9:0] osc_trim,
   output var  logic [4:0] osc_band,
   output var  logic       dither_on,
   output var  logic       dither_2pct,
   // Storage
   output var  logic       nv_busy,
   output var  logic [23:0] nv_image
);

   // ********************************
   // Pin synchronisers
   // ********************************
   // Bits: 4 scl, 3 sda, 2 gate, 1 power-down, 0 dither.
   logic [4:0]  s1_q;
   logic [4:0]  s2_q;
   logic [1:0]  s3_q;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_c;
   logic        stop_c;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_q <= 5'h1F;
         s2_q <= 5'h1F;
         s3_q <= 2'b11;
      end else begin
         s1_q <= {lnk.scl, lnk.sda, lnk.out_gate, lnk.power_down_n,
                  lnk.dither_enable_pin};
         s2_q <= s1_q;
         s3_q <= s2_q[4:3];
      end
   end

   assign scl_rise = s2_q[4] & ~s3_q[1];
   assign scl_fall = ~s2_q[4] & s3_q[1];
   assign start_c  = s2_q[4] & s3_q[1] & ~s2_q[3] & s3_q[0];
   assign stop_c   = s2_q[4] & s3_q[1] & s2_q[3] & ~s3_q[0];

   // ********************************
   // Settings registers
   // ********************************
   logic [4:0]  div_q;
   logic [7:0]  thi_q;
   logic [1:0]  tlo_q;
   logic [4:0]  band_q;
   logic [3:0]  adr_q;
   sl_state_t   st_q;
   logic [3:0]  bitc_q;
   logic [7:0]  sh_q;
   logic [7:0]  ptr_q;
   logic        rw_q;
   logic        sda_oe_q;
   logic        nv_busy_q;
   logic        wr_stb;
   logic        id_hit;
   logic [7:0]  rd_byte;

   assign wr_stb = scl_fall && bitc_q == 4'd8 && st_q == SL_WDATA;
   assign id_hit = sh_q[7:1] == {DEV_ID, adr_q[2:0]};

   always_comb begin
      case (ptr_q)
         `PTR_DIV:     rd_byte = {`FILL_DIV, div_q};
         `PTR_TRIM_HI: rd_byte = thi_q;
         `PTR_TRIM_LO: rd_byte = {tlo_q, 6'h00};
         `PTR_BAND:    rd_byte = {`FILL_BAND, band_q};
         `PTR_ADDR:    rd_byte = {`FILL_ADDR, adr_q};
         `PTR_FBAND:   rd_byte = {3'b000, FACTORY_BAND};
         default:      rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_q  <= `RST_DIV;
         thi_q  <= `RST_TRIM_HI;
         tlo_q  <= `RST_TRIM_LO;
         band_q <= FACTORY_BAND;
         adr_q  <= `RST_ADDR;
      end else if (wr_stb) begin
         case (ptr_q)
            `PTR_DIV:     div_q  <= sh_q[4:0];
            `PTR_TRIM_HI: thi_q  <= sh_q;
            `PTR_TRIM_LO: tlo_q  <= sh_q[7:6];
            `PTR_BAND:    band_q <= sh_q[4:0];
            `PTR_ADDR:    adr_q  <= sh_q[3:0];
            default:      ;
         endcase
      end
   end

   // ********************************
   // Two-wire slave
   // ********************************
   // Pointer advances after each data byte, so the trim pair can be
   // written or read in one transfer.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q     <= SL_IDLE;
         bitc_q   <= 4'd0;
         sh_q     <= 8'h00;
         ptr_q    <= 8'h00;
         rw_q     <= 1'b0;
         sda_oe_q <= 1'b0;
      end else if (start_c) begin
         st_q     <= SL_ADDR;
         bitc_q   <= 4'd0;
         sda_oe_q <= 1'b0;
      end else if (stop_c) begin
         st_q     <= SL_IDLE;
         sda_oe_q <= 1'b0;
      end else if (st_q != SL_IDLE) begin
         if (scl_rise && bitc_q < 4'd8) begin
            sh_q   <= {sh_q[6:0], s2_q[3]};
            bitc_q <= bitc_q + 4'd1;
         end else if (scl_rise && bitc_q == 4'd8) begin
            bitc_q <= 4'd9;
            if (st_q == SL_RDATA && s2_q[3]) begin
               st_q <= SL_IDLE;
            end
         end else if (scl_fall && bitc_q == 4'd8) begin
            if (st_q == SL_RDATA) begin
               sda_oe_q <= 1'b0;
               ptr_q    <= ptr_q + 8'd1;
            end else if (st_q == SL_ADDR && (!id_hit || nv_busy_q)) begin
               st_q     <= SL_IDLE;
               sda_oe_q <= 1'b0;
            end else begin
               sda_oe_q <= 1'b1;
               if (st_q == SL_ADDR) begin
                  rw_q <= sh_q[0];
               end else if (st_q == SL_PTR) begin
                  ptr_q <= sh_q;
               end else begin
                  ptr_q <= ptr_q + 8'd1;
               end
            end
         end else if (scl_fall && bitc_q == 4'd9) begin
            bitc_q <= 4'd0;
            if ((st_q == SL_ADDR && rw_q) || st_q == SL_RDATA) begin
               st_q     <= SL_RDATA;
               sh_q     <= rd_byte;
               sda_oe_q <= ~rd_byte[7];
            end else begin
               sda_oe_q <= 1'b0;
               st_q     <= (st_q == SL_ADDR) ? SL_PTR : SL_WDATA;
            end
         end else if (scl_fall && st_q == SL_RDATA && bitc_q != 4'd0) begin
            sda_oe_q <= ~sh_q[7];
         end
      end
   end

   // ********************************
   // Storage commit
   // ********************************
   logic        dirty_q;
   logic        adr_dirty_q;
   logic        commit_q;
   logic        nv_go;
   logic [15:0] nv_cnt_q;
   logic [23:0] nv_img_q;

   assign nv_go = stop_c && !nv_busy_q && ((dirty_q && !adr_q[3])
                  || adr_dirty_q || commit_q);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dirty_q     <= 1'b0;
         adr_dirty_q <= 1'b0;
         commit_q    <= 1'b0;
      end else if (nv_go) begin
         dirty_q     <= 1'b0;
         adr_dirty_q <= 1'b0;
         commit_q    <= 1'b0;
      end else begin
         if (wr_stb && (ptr_q == `PTR_DIV || ptr_q == `PTR_TRIM_HI ||
             ptr_q == `PTR_TRIM_LO || ptr_q == `PTR_BAND)) begin
            dirty_q <= 1'b1;
         end
         if (wr_stb && ptr_q == `PTR_ADDR) begin
            adr_dirty_q <= 1'b1;
         end
         if (scl_fall && bitc_q == 4'd8 && st_q == SL_PTR &&
             sh_q == `PTR_COMMIT) begin
            commit_q <= 1'b1;
         end
      end
   end

   // Settings are copied at the end of the write time, so a change
   // made meanwhile is refused by the slave and cannot slip in.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         nv_busy_q <= 1'b0;
         nv_cnt_q  <= 16'h0000;
         nv_img_q  <= {`RST_DIV, `RST_TRIM_HI, `RST_TRIM_LO,
                       FACTORY_BAND, `RST_ADDR};
      end else if (nv_go) begin
         nv_busy_q <= 1'b1;
         nv_cnt_q  <= 16'(NV_WRITE_CYC - 1);
      end else if (nv_busy_q && nv_cnt_q != 16'h0000) begin
         nv_cnt_q <= nv_cnt_q - 16'd1;
      end else if (nv_busy_q) begin
         nv_busy_q <= 1'b0;
         nv_img_q  <= {div_q, thi_q, tlo_q, band_q, adr_q};
      end
   end

   // ********************************
   // Output divider and gating
   // ********************************
   logic [8:0]  cnt_q;
   logic [9:0]  stab_q;
   logic        en_q;
   logic        out_q;
   logic [3:0]  exp_c;

   assign exp_c = (div_q[3:0] > `EXP_MAX) ? `EXP_MAX : div_q[3:0];

   // The enable only changes while the divided clock is low, so gating
   // starts and stops on whole pulses; power-down clears the output at once.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q  <= 9'h000;
         stab_q <= 10'h000;
         en_q   <= 1'b0;
         out_q  <= 1'b0;
      end else if (!s2_q[1]) begin
         cnt_q  <= 9'h000;
         stab_q <= 10'h000;
         en_q   <= 1'b0;
         out_q  <= 1'b0;
      end else begin
         cnt_q <= cnt_q + 9'd1;
         if (cnt_q[0] && stab_q != `STAB_CYC) begin
            stab_q <= stab_q + 10'd1;
         end
         if (!cnt_q[exp_c]) begin
            en_q <= s2_q[2] && stab_q == `STAB_CYC;
         end
         out_q <= en_q & cnt_q[exp_c];
      end
   end

   // ********************************
   // Core controls
   // ********************************
   logic        run_q;
   logic [9:0]  trim_q;
   logic [4:0]  bsel_q;
   logic        don_q;
   logic        d2_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run_q  <= 1'b0;
         trim_q <= 10'h000;
         bsel_q <= 5'h00;
         don_q  <= 1'b0;
         d2_q   <= 1'b0;
      end else begin
         run_q  <= s2_q[1];
         trim_q <= {thi_q, tlo_q};
         bsel_q <= band_q;
         don_q  <= s2_q[0] & s2_q[1];
         d2_q   <= div_q[4];
      end
   end

   assign osc_run        = run_q;
   assign osc_trim       = trim_q;
   assign osc_band       = bsel_q;
   assign dither_on      = don_q;
   assign dither_2pct    = d2_q;
   assign nv_busy        = nv_busy_q;
   assign nv_image       = nv_img_q;
   assign lnk.sda_dev_oe = sda_oe_q;
   assign lnk.clk_out    = out_q;

endmodule // dither_clk_dev
`default_nettype wire

// file: dither_clk_host.sv
// Purpose: Host end: AHB-Lite registers, two-wire master and pins.
// Assumes: Single word transfers; the slave never waits.
// Notes:   Software polls the busy bit and retries on a refusal.
`timescale 1ns/1ps
`default_nettype none
`include "clk_ctrl_consts.svh"
module dither_clk_host
   import clk_ctrl_pkg::*;
#(
   parameter int QTR         = `LINK_QTR_CYC,
   parameter int PD_HOLD_CYC = `PD_HOLD_CYC
) (
   // System
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output var  logic        hreadyout,
   output var  logic [31:0] hrdata,
   output var  logic        hresp,
   // Link
   clk_ctrl_link_if.host    lnk
);

   // ********************************
   // Bus slave
   // ********************************
   logic        wpend_q;
   logic [7:0]  waddr_q;
   logic [31:0] rdata_bus_q;
   logic [2:0]  ctrl_q;
   logic [7:0]  ptr_q;
   logic [1:0]  nb_q;
   logic        rd_q;
   logic [15:0] data_q;
   logic [6:0]  slv_q;
   logic        nack_q;
   logic [15:0] rdat_q;
   logic        busy;
   logic        go;
   m_state_t    st_q;
   logic [31:0] rmux;

   assign busy = st_q != M_IDLE;
   assign go   = wpend_q && waddr_q == `HA_CMD && !busy;

   always_comb begin
      case (haddr[7:0])
         `HA_CTRL:  rmux = {29'h0, ctrl_q};
         `HA_CMD:   rmux = {21'h0, rd_q, nb_q, ptr_q};
         `HA_DATA:  rmux = {16'h0, data_q};
         `HA_STAT:  rmux = {8'h0, rdat_q, 6'h0, nack_q, busy};
         `HA_SLAVE: rmux = {25'h0, slv_q};
         default:   rmux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wpend_q     <= 1'b0;
         waddr_q     <= 8'h00;
         rdata_bus_q <= 32'h0000_0000;
      end else begin
         wpend_q <= hsel && htrans[1] && hready && hwrite;
         waddr_q <= haddr[7:0];
         if (hsel && htrans[1] && hready && !hwrite) begin
            rdata_bus_q <= rmux;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= `RST_CTRL;
         ptr_q  <= 8'h00;
         nb_q   <= 2'd0;
         rd_q   <= 1'b0;
         data_q <= 16'h0000;
         slv_q  <= `RST_SLAVE;
      end else if (wpend_q) begin
         case (waddr_q)
            `HA_CTRL:  ctrl_q <= hwdata[2:0];
            `HA_DATA:  data_q <= hwdata[15:0];
            `HA_SLAVE: slv_q  <= hwdata[6:0];
            `HA_CMD: begin
               if (!busy) begin
                  ptr_q <= hwdata[7:0];
                  nb_q  <= hwdata[9:8];
                  rd_q  <= hwdata[10];
               end
            end
            default: ;
         endcase
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_bus_q;

   // ********************************
   // Control pins
   // ********************************
   logic        pdn_q;
   logic [10:0] hold_q;

   // A release asked for too early waits until the low time is served.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pdn_q  <= 1'b1;
         hold_q <= 11'd0;
      end else if (hold_q != 11'd0) begin
         hold_q <= hold_q - 11'd1;
      end else if (pdn_q != ctrl_q[1]) begin
         pdn_q <= ctrl_q[1];
         if (!ctrl_q[1]) begin
            hold_q <= 11'(PD_HOLD_CYC - 1);
         end
      end
   end

   assign lnk.out_gate          = ctrl_q[0];
   assign lnk.power_down_n      = pdn_q;
   assign lnk.dither_enable_pin = ctrl_q[2];

   // ********************************
   // Two-wire master
   // ********************************
   logic [1:0]  sda_s_q;
   logic [7:0]  tq_q;
   logic        tick;
   logic [1:0]  ph_q;
   logic [3:0]  bit_q;
   logic [2:0]  bi_q;
   logic [7:0]  sh_q;
   logic        scl_oe_q;
   logic        sda_oe_q;
   logic [7:0]  nxt;
   logic [7:0]  d;
   logic        last;

   assign tick = tq_q == 8'(QTR - 1);
   assign last = (bi_q + 3'd1) >= {1'b0, nb_q};
   assign d    = (bit_q == 4'd0) ? nxt : sh_q;

   always_comb begin
      case (bi_q)
         3'd0:    nxt = {slv_q, 1'b0};
         3'd1:    nxt = ptr_q;
         3'd2:    nxt = (nb_q == 2'd2) ? data_q[15:8] : data_q[7:0];
         3'd3:    nxt = data_q[7:0];
         default: nxt = {slv_q, 1'b1};
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sda_s_q <= 2'b11;
         tq_q    <= 8'h00;
      end else begin
         sda_s_q <= {sda_s_q[0], lnk.sda};
         tq_q    <= (tick || !busy) ? 8'h00 : tq_q + 8'd1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q     <= M_IDLE;
         ph_q     <= 2'd0;
         bit_q    <= 4'd0;
         bi_q     <= 3'd0;
         sh_q     <= 8'h00;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
         nack_q   <= 1'b0;
         rdat_q   <= 16'h0000;
      end else if (go) begin
         st_q   <= M_START;
         ph_q   <= 2'd0;
         bi_q   <= 3'd0;
         nack_q <= 1'b0;
      end else if (busy && tick) begin
         ph_q <= ph_q + 2'd1;
         case (st_q)
            M_START: begin
               case (ph_q)
                  2'd0:    sda_oe_q <= 1'b0;
                  2'd1:    scl_oe_q <= 1'b0;
                  2'd2:    sda_oe_q <= 1'b1;
                  default: begin
                     scl_oe_q <= 1'b1;
                     bit_q    <= 4'd0;
                     st_q     <= M_WBYTE;
                  end
               endcase
            end
            M_WBYTE, M_RBYTE: begin
               case (ph_q)
                  2'd0: begin
                     if (bit_q == 4'd8) begin
                        sda_oe_q <= (st_q == M_RBYTE) && !last;
                     end else if (st_q == M_RBYTE) begin
                        sda_oe_q <= 1'b0;
                     end else begin
                        sda_oe_q <= ~d[7];
                        sh_q     <= {d[6:0], 1'b0};
                     end
                  end
                  2'd1: scl_oe_q <= 1'b0;
                  2'd2: begin
                     if (st_q == M_RBYTE && bit_q != 4'd8) begin
                        sh_q <= {sh_q[6:0], sda_s_q[1]};
                     end
                     if (st_q == M_WBYTE && bit_q == 4'd8 && sda_s_q[1]) begin
                        nack_q <= 1'b1;
                     end
                  end
                  default: begin
                     scl_oe_q <= 1'b1;
                     bit_q    <= (bit_q == 4'd8) ? 4'd0 : bit_q + 4'd1;
                     if (bit_q == 4'd8 && st_q == M_RBYTE) begin
                        rdat_q <= {rdat_q[7:0], sh_q};
                        bi_q   <= bi_q + 3'd1;
                        st_q   <= last ? M_STOP : M_RBYTE;
                     end else if (bit_q == 4'd8) begin
                        if (nack_q) begin
                           st_q <= M_STOP;
                        end else if (bi_q == 3'd4) begin
                           st_q <= M_RBYTE;
                           bi_q <= 3'd0;
                        end else if (rd_q && bi_q == 3'd1) begin
                           st_q <= M_START;
                           bi_q <= 3'd4;
                        end else if (bi_q < {1'b0, nb_q} + 3'd1) begin
                           bi_q <= bi_q + 3'd1;
                        end else begin
                           st_q <= M_STOP;
                        end
                     end
                  end
               endcase
            end
            M_STOP: begin
               case (ph_q)
                  2'd0:    sda_oe_q <= 1'b1;
                  2'd1:    scl_oe_q <= 1'b0;
                  2'd2:    sda_oe_q <= 1'b0;
                  default: st_q     <= M_IDLE;
               endcase
            end
            default: st_q <= M_IDLE;
         endcase
      end
   end

   assign lnk.scl_oe      = scl_oe_q;
   assign lnk.sda_host_oe = sda_oe_q;

endmodule // dither_clk_host
`default_nettype wire

// file: clk_ctrl_checker.sv
// Purpose: Wire-level checks of the clock controller link.
// Assumes: One hclk domain.
// Notes:   Delays of five or eight cycles allow for the input synchronisers.
`timescale 1ns/1ps
`default_nettype none
module clk_ctrl_checker (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Link
   input wire logic scl,
   input wire logic sda_dev_oe,
   input wire logic out_gate,
   input wire logic power_down_n,
   input wire logic clk_out
);
   // ****
   // Checks
   // ****
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [10:0] up_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) up_q <= 11'h000;
      else if (!up_q[10]) up_q <= up_q + 11'h001;
   end
   a_start_delay: assert property (clk_out |-> up_q[10])
      else $error("output before start-up delay");
   a_pd_quiet: assert property (
      !power_down_n [*8] ##0 !clk_out |=> !clk_out) else $error("pd output");
   a_pd_stops_out: assert property (
      !power_down_n [*5] |-> !clk_out) else $error("pd left output on");
   a_gate_quiet: assert property (
      !out_gate [*8] ##0 !clk_out |=> !clk_out) else $error("gated output");
   a_pd_hold: assert property (
      $fell(power_down_n) |=> !power_down_n [*8]) else $error("pd too short");
   a_sda_in_low: assert property ($changed(sda_dev_oe) |-> !scl)
      else $error("sda moved with scl high");
endmodule // clk_ctrl_checker
`default_nettype wire

// file: programmable_dithered_clock_ctrl_tb_top.sv
// Purpose: Host and device joined over the link, driven over AHB-Lite.
// Assumes: Short storage and hold counts keep the run brief.
// Notes:   Storage waits use the device busy flag.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
   $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module programmable_dithered_clock_ctrl_tb_top;
   typedef struct {logic rd; logic [7:0] p; logic [1:0] n; logic [15:0] d;} row_t;
   logic        hclk, hresetn, hwrite, hready;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata;
   logic        osc_run, dither_on, dither_2pct, nv_busy;
   logic [9:0]  osc_trim;
   logic [4:0]  osc_band;
   logic [23:0] nv_image;
   int          n_mismatch, checks_done;
   row_t rows [7] = '{'{0, 8'h02, 1, 16'h0013}, '{1, 8'h02, 1, 16'h00F3},
      '{0, 8'h08, 2, 16'hA3C0}, '{1, 8'h08, 2, 16'hA3C0},
      '{1, 8'h37, 1, 16'hC012}, '{0, 8'h0E, 1, 16'h0010},
      '{1, 8'h0E, 1, 16'h12F0}};
   clk_ctrl_link_if lnk ();
   dither_clk_dev #(.NV_WRITE_CYC(300)) u_dither_clk_dev (.hclk, .hresetn,
      .lnk, .osc_run, .osc_trim, .osc_band, .dither_on, .dither_2pct,
      .nv_busy, .nv_image);
   dither_clk_host #(.PD_HOLD_CYC(20)) u_dither_clk_host (.hclk, .hresetn,
      .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
      .hreadyout(hready), .hrdata, .hresp(), .lnk);
   clk_ctrl_checker u_clk_ctrl_checker (.hclk, .hresetn, .scl(lnk.scl),
      .sda_dev_oe(lnk.sda_dev_oe), .out_gate(lnk.out_gate),
      .power_down_n(lnk.power_down_n), .clk_out(lnk.clk_out));
   // ****
   // Tasks
   // ****
   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0; hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic xfer(input logic rd, input logic [7:0] p,
                       input logic [1:0] n, input logic [15:0] d,
                       output logic [31:0] s);
      int i;
      ahb(1, 8'h08, {16'h0, d}, s);
      ahb(1, 8'h04, {21'h0, rd, n, p}, s);
      s = 32'h1;
      for (i = 0; i < 9000 && s[0] !== 1'b0; i++) ahb(0, 8'h0C, 32'h0, s);
      `CHK(s[0], 1'b0)
   endtask
   task automatic settle;
      int i;
      for (i = 0; i < 400 && nv_busy !== 1'b0; i++) @(posedge hclk);
      `CHK(nv_busy, 1'b0)
   endtask
   // A rise is taken only after a low sample, so periods are whole.
   task automatic per(output int c);
      int i, r0, r1;
      logic p;
      p = 1; r0 = 0; r1 = 0;
      for (i = 1; i < 3000 && r1 == 0; i++) begin
         @(posedge hclk);
         if (lnk.clk_out === 1'b1 && p === 1'b0) begin
            if (r0 == 0) r0 = i; else r1 = i;
         end
         p = lnk.clk_out;
      end
      c = r1 - r0;
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      hclk = 0;
      forever #20 hclk = ~hclk;
   end
   initial begin
      #(40 * 60000);
      n_mismatch++;
      report_and_stop;
   end
   initial begin
      logic [31:0] r, s;
      int c;
      hresetn = 0; htrans = 0; hwrite = 0; haddr = 0; hwdata = 0;
      repeat (20) @(posedge hclk);
      hresetn <= 1;
      @(posedge hclk);
      `CHK(lnk.clk_out, 1'b0)
      ahb(0, 8'h00, 32'h0, r); `CHK(r, 32'h3)
      ahb(0, 8'h20, 32'h0, r); `CHK(r, 32'h0)
      $display("reset done");
      foreach (rows[k]) begin
         xfer(rows[k].rd, rows[k].p, rows[k].n, rows[k].d, s);
         settle;
         if (rows[k].rd) `CHK(s[23:8], rows[k].d)
         else `CHK(s[1], 1'b0)
         $display("row %0d done", k);
      end
      `CHK(osc_trim, 10'h28F)
      `CHK(osc_band, 5'h10)
      `CHK(dither_2pct, 1'b1)
      `CHK(nv_image[23:19], 5'h13)
      per(c); `CHK(c, 16)
      xfer(0, 8'h02, 1, 16'h0009, s);
      xfer(1, 8'h02, 1, 16'h0, s); `CHK(s[1], 1'b1)
      settle; per(c); `CHK(c, 512)
      xfer(0, 8'h0D, 1, 16'h0008, s); settle; `CHK(nv_image[3:0], 4'h8)
      xfer(0, 8'h0E, 1, 16'h0011, s); settle; `CHK(nv_image[8:4], 5'h10)
      xfer(0, 8'h3F, 0, 16'h0, s); settle; `CHK(nv_image[8:4], 5'h11)
      $display("storage done");
      ahb(1, 8'h00, 32'h7, r); repeat (10) @(posedge hclk);
      `CHK(dither_on, 1'b1)
      ahb(1, 8'h00, 32'h5, r); repeat (40) @(posedge hclk);
      `CHK(osc_run, 1'b0)
      `CHK(dither_on, 1'b0)
      ahb(1, 8'h00, 32'h2, r); repeat (600) @(posedge hclk);
      `CHK(osc_run, 1'b1)
      `CHK(lnk.clk_out, 1'b0)
      ahb(1, 8'h00, 32'h3, r); per(c); `CHK(c, 512)
      $display("pins done");
      report_and_stop;
   end
endmodule // programmable_dithered_clock_ctrl_tb_top
`default_nettype wire
